/* File: lss_defs.svh */
/*
 * Offsets, bit positions, codes and reset values of the LCD status and
 * subpanel block. Assumes a byte address on a 32-bit register port.
 */
`ifndef LSS_DEFS_SVH
`define LSS_DEFS_SVH

`define LSS_CTRL_OFS 8'h00
`define LSS_TIMING2_OFS 8'h08
`define LSS_STATUS_OFS 8'h0c
`define LSS_DISP_OFS 8'h10
`define LSS_SUBPANEL_OFS 8'h14
`define LSS_LINE_INT_OFS 8'h18

`define LSS_CTRL_ON 0
`define LSS_CTRL_FRAME_UNMASK 1
`define LSS_CTRL_LINE_PIN_MASK 2
`define LSS_CTRL_LINE_SHARED_MASK 3
`define LSS_CTRL_LINE_CLR_SEL 4
`define LSS_CTRL_BIAS_UNMASK 5
`define LSS_CTRL_UNDERRUN_UNMASK 6
`define LSS_CTRL_SYNC_UNMASK 7
`define LSS_CTRL_PALETTE_UNMASK 8
`define LSS_CTRL_PLM_LO 20
`define LSS_CTRL_PLM_HI 21

`define LSS_T2_BIAS_LO 0

`define LSS_ST_DONE 0
`define LSS_ST_FRAME_END 1
`define LSS_ST_SYNC 2
`define LSS_ST_BIAS 3
`define LSS_ST_LINE 4
`define LSS_ST_UNDERRUN 5
`define LSS_ST_PALETTE 6

`define LSS_SP_ON 31
`define LSS_SP_ABOVE 29
`define LSS_SP_THR_HI 25
`define LSS_SP_THR_LO 16
`define LSS_SP_FILL_HI 15
`define LSS_SP_FILL_LO 0

`define LSS_PLM_BOTH 2'h0
`define LSS_PLM_PALETTE 2'h1
`define LSS_PLM_DATA 2'h2

`define LSS_SUBPANEL_RST 32'h0000_0000
`define LSS_LINE_INT_RST 10'h000

`endif

/* File: lss_pkg.sv */
/*
 * Shared types of the LCD status and subpanel block.
 * Assumes lss_defs.svh sits in the same folder.
 */
package lss_pkg;
    typedef logic [9:0] lss_line_t;
    typedef logic [15:0] lss_pix_t;
    typedef logic [31:0] lss_word_t;
    typedef logic [7:0] lss_addr_t;
    typedef logic [1:0] lss_plm_t;
endpackage

/* File: lss_bias_counter.sv */
/*
 * Down counter of ac-bias reversals between two bias-count events.
 * Assumes the toggle pulse and the hold level come from core_clk logic.
 */
`timescale 1ns/1ps
module lss_bias_counter import lss_pkg::*; #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] load_value,
    input wire logic toggle,
    input wire logic hold,
    output logic hit,
    output logic [W-1:0] count
);
    // A zero field disables counting altogether
    assign hit = toggle && !hold && (load_value != '0) &&
                 (count == W'(1));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (load_value == '0) begin
            count <= '0;
        end else if (count == '0 || hit) begin
            count <= load_value;
        end else if (toggle && !hold) begin
            count <= count - W'(1);
        end
    end
endmodule

/* File: lss_subpanel_sel.sv */
/*
 * Decides whether the current line shows frame-buffer video or fill.
 * Assumes line 0 is the bottom line of the panel.
 */
`timescale 1ns/1ps
module lss_subpanel_sel import lss_pkg::*; (
    input wire logic on,
    input wire logic above,
    input wire lss_line_t threshold,
    input wire lss_line_t lines_per_panel,
    input wire lss_line_t line,
    output logic show_video
);
    always_comb begin
        if (!on) begin
            show_video = 1'b1;
        end else if (threshold > lines_per_panel) begin
            show_video = !above;
        end else if (above) begin
            // Threshold line itself is fill here
            show_video = line > threshold;
        end else begin
            show_video = line <= threshold;
        end
    end
endmodule

/* File: lss_status_subpanel.sv */
/*
 * Status flags, interrupt gating and subpanel pixel selection of an LCD
 * controller. Assumes every event input is a one-cycle pulse from logic
 * on core_clk, and that the register port master never needs a wait.
 */
`timescale 1ns/1ps
`include "lss_defs.svh"
module lss_status_subpanel import lss_pkg::*; #(
    parameter int BIAS_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire lss_addr_t reg_addr,
    input wire lss_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output lss_word_t reg_rdata,
    input wire logic frame_end,
    input wire logic sync_bad,
    input wire logic bias_toggle,
    input wire logic line_start,
    input wire logic line_end,
    input wire lss_line_t current_line,
    input wire lss_line_t lines_per_panel,
    input wire logic fifo_empty,
    input wire logic pix_take,
    input wire logic palette_done,
    input wire lss_pix_t video_pixel,
    output lss_pix_t pixel_out,
    output logic dma_fetch_en,
    output logic fifo_reset,
    output logic controller_on,
    output logic irq_b,
    output logic line_irq_b
);
    logic frame_end_unmask, line_irq_mask, line_nirq_mask, line_clr_sel;
    logic bias_unmask, underrun_unmask, sync_unmask, palette_unmask;
    lss_plm_t palette_load_mode;
    logic [BIAS_W-1:0] bias_toggles_per_irq;
    logic subpanel_on;
    logic video_above_threshold;
    lss_line_t subpanel_threshold_line;
    lss_pix_t fill_pixel_value;
    lss_line_t line_int_number;
    logic frame_done_flag, frame_end_flag, sync_lost_flag, bias_count_flag;
    logic line_hit_flag, fifo_underrun_flag, palette_loaded_flag;
    logic wr_ctrl, wr_stat, off_pulse, on_pulse;
    logic bias_hit;
    logic [BIAS_W-1:0] bias_count;
    logic show_video;
    logic line_match;
    logic underrun_ev;
    logic shared_any;
    lss_word_t status_word;
    lss_word_t ctrl_word;
    lss_word_t next_rdata;

    assign wr_ctrl = reg_wr && (reg_addr == `LSS_CTRL_OFS);
    assign wr_stat = reg_wr && (reg_addr == `LSS_STATUS_OFS);
    assign off_pulse = wr_ctrl && controller_on && !reg_wdata[`LSS_CTRL_ON];
    assign on_pulse = wr_ctrl && !controller_on && reg_wdata[`LSS_CTRL_ON];
    assign line_match = current_line == line_int_number;
    assign underrun_ev = controller_on && pix_take && fifo_empty;

    // Control register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            controller_on <= 1'b0;
            frame_end_unmask <= 1'b0;
            line_irq_mask <= 1'b0;
            line_nirq_mask <= 1'b0;
            line_clr_sel <= 1'b0;
            bias_unmask <= 1'b0;
            underrun_unmask <= 1'b0;
            sync_unmask <= 1'b0;
            palette_unmask <= 1'b0;
            palette_load_mode <= `LSS_PLM_BOTH;
        end else if (wr_ctrl) begin
            controller_on <= reg_wdata[`LSS_CTRL_ON];
            frame_end_unmask <= reg_wdata[`LSS_CTRL_FRAME_UNMASK];
            line_irq_mask <= reg_wdata[`LSS_CTRL_LINE_PIN_MASK];
            line_nirq_mask <= reg_wdata[`LSS_CTRL_LINE_SHARED_MASK];
            line_clr_sel <= reg_wdata[`LSS_CTRL_LINE_CLR_SEL];
            bias_unmask <= reg_wdata[`LSS_CTRL_BIAS_UNMASK];
            underrun_unmask <= reg_wdata[`LSS_CTRL_UNDERRUN_UNMASK];
            sync_unmask <= reg_wdata[`LSS_CTRL_SYNC_UNMASK];
            palette_unmask <= reg_wdata[`LSS_CTRL_PALETTE_UNMASK];
            palette_load_mode <= reg_wdata[`LSS_CTRL_PLM_HI:`LSS_CTRL_PLM_LO];
        end
    end

    // Timing, subpanel and line-number registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bias_toggles_per_irq <= '0;
            subpanel_on <= 1'b0;
            video_above_threshold <= 1'b0;
            subpanel_threshold_line <= '0;
            fill_pixel_value <= '0;
            line_int_number <= `LSS_LINE_INT_RST;
        end else if (reg_wr) begin
            if (reg_addr == `LSS_TIMING2_OFS) begin
                bias_toggles_per_irq <=
                    reg_wdata[`LSS_T2_BIAS_LO +: BIAS_W];
            end
            if (reg_addr == `LSS_SUBPANEL_OFS) begin
                subpanel_on <= reg_wdata[`LSS_SP_ON];
                video_above_threshold <= reg_wdata[`LSS_SP_ABOVE];
                subpanel_threshold_line <=
                    reg_wdata[`LSS_SP_THR_HI:`LSS_SP_THR_LO];
                fill_pixel_value <=
                    reg_wdata[`LSS_SP_FILL_HI:`LSS_SP_FILL_LO];
            end
            if (reg_addr == `LSS_LINE_INT_OFS) begin
                line_int_number <= reg_wdata[9:0];
            end
        end
    end

    // Frame done: set on any frame end while the controller is off, also before a first enable
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_done_flag <= 1'b0;
        end else if (frame_end && !controller_on) begin
            frame_done_flag <= 1'b1;
        end else if (on_pulse) begin
            frame_done_flag <= 1'b0;
        end
    end

    // Set is tested first so a coinciding clear write never loses it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_end_flag <= 1'b0;
        end else if (frame_end) begin
            frame_end_flag <= 1'b1;
        end else if (wr_stat && !reg_wdata[`LSS_ST_FRAME_END]) begin
            frame_end_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_lost_flag <= 1'b0;
        end else if (controller_on && sync_bad) begin
            sync_lost_flag <= 1'b1;
        end else if (off_pulse) begin
            sync_lost_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_underrun_flag <= 1'b0;
        end else if (underrun_ev) begin
            fifo_underrun_flag <= 1'b1;
        end else if (off_pulse) begin
            fifo_underrun_flag <= 1'b0;
        end
    end

    // Turning the controller off flushes the DMA input FIFO
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_reset <= 1'b0;
        end else begin
            fifo_reset <= off_pulse;
        end
    end

    lss_bias_counter #(
        .W(BIAS_W)
    ) u_bias (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .load_value(bias_toggles_per_irq),
        .toggle(bias_toggle),
        .hold(bias_count_flag),
        .hit(bias_hit),
        .count(bias_count)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bias_count_flag <= 1'b0;
        end else if (bias_hit) begin
            bias_count_flag <= 1'b1;
        end else if (wr_stat && !reg_wdata[`LSS_ST_BIAS]) begin
            bias_count_flag <= 1'b0;
        end
    end

    // Auto clear only ends the matching line, not any line
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_hit_flag <= 1'b0;
        end else if (line_start && line_match) begin
            line_hit_flag <= 1'b1;
        end else if (line_clr_sel && line_end && line_match) begin
            line_hit_flag <= 1'b0;
        end else if (!line_clr_sel && wr_stat &&
                     !reg_wdata[`LSS_ST_LINE]) begin
            line_hit_flag <= 1'b0;
        end
    end

    // Mode 11 is undefined; it is handled like the write-clear modes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            palette_loaded_flag <= 1'b0;
        end else if (palette_done) begin
            palette_loaded_flag <= 1'b1;
        end else if (palette_load_mode == `LSS_PLM_PALETTE) begin
            if (off_pulse) begin
                palette_loaded_flag <= 1'b0;
            end
        end else if (wr_stat && !reg_wdata[`LSS_ST_PALETTE]) begin
            palette_loaded_flag <= 1'b0;
        end
    end

    assign shared_any =
        (frame_end_flag && frame_end_unmask) ||
        (line_hit_flag && line_nirq_mask) ||
        (bias_count_flag && bias_unmask) ||
        (fifo_underrun_flag && underrun_unmask) ||
        (sync_lost_flag && sync_unmask) ||
        (palette_loaded_flag && palette_unmask);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_b <= 1'b1;
            line_irq_b <= 1'b1;
        end else begin
            irq_b <= !shared_any;
            line_irq_b <= !(line_hit_flag && line_irq_mask);
        end
    end

    lss_subpanel_sel u_sel (
        .on(subpanel_on),
        .above(video_above_threshold),
        .threshold(subpanel_threshold_line),
        .lines_per_panel(lines_per_panel),
        .line(current_line),
        .show_video(show_video)
    );

    // Fill lines need no frame-buffer data, so fetching stops there
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pixel_out <= '0;
            dma_fetch_en <= 1'b0;
        end else begin
            pixel_out <= show_video ? video_pixel : fill_pixel_value;
            dma_fetch_en <= controller_on && show_video;
        end
    end

    assign status_word = {25'h0, palette_loaded_flag, fifo_underrun_flag,
                          line_hit_flag, bias_count_flag, sync_lost_flag,
                          frame_end_flag, frame_done_flag};

    always_comb begin
        ctrl_word = '0;
        ctrl_word[`LSS_CTRL_ON] = controller_on;
        ctrl_word[`LSS_CTRL_FRAME_UNMASK] = frame_end_unmask;
        ctrl_word[`LSS_CTRL_LINE_PIN_MASK] = line_irq_mask;
        ctrl_word[`LSS_CTRL_LINE_SHARED_MASK] = line_nirq_mask;
        ctrl_word[`LSS_CTRL_LINE_CLR_SEL] = line_clr_sel;
        ctrl_word[`LSS_CTRL_BIAS_UNMASK] = bias_unmask;
        ctrl_word[`LSS_CTRL_UNDERRUN_UNMASK] = underrun_unmask;
        ctrl_word[`LSS_CTRL_SYNC_UNMASK] = sync_unmask;
        ctrl_word[`LSS_CTRL_PALETTE_UNMASK] = palette_unmask;
        ctrl_word[`LSS_CTRL_PLM_HI:`LSS_CTRL_PLM_LO] = palette_load_mode;
    end

    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        next_rdata = '0;
        unique case (reg_addr)
            `LSS_CTRL_OFS: next_rdata = ctrl_word;
            `LSS_TIMING2_OFS: next_rdata[`LSS_T2_BIAS_LO +: BIAS_W] =
                bias_toggles_per_irq;
            `LSS_STATUS_OFS: next_rdata = status_word;
            `LSS_DISP_OFS: next_rdata[9:0] = current_line;
            `LSS_SUBPANEL_OFS: begin
                next_rdata[`LSS_SP_ON] = subpanel_on;
                next_rdata[`LSS_SP_ABOVE] = video_above_threshold;
                next_rdata[`LSS_SP_THR_HI:`LSS_SP_THR_LO] =
                    subpanel_threshold_line;
                next_rdata[`LSS_SP_FILL_HI:`LSS_SP_FILL_LO] =
                    fill_pixel_value;
            end
            `LSS_LINE_INT_OFS: next_rdata[9:0] = line_int_number;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_frame_event;
        frame_end;
    endsequence
    sequence s_frame_raised;
        frame_end_flag ##1 (!$past(frame_end_unmask) || !irq_b);
    endsequence
    a_frame_end_set: assert property (
        s_frame_event |=> s_frame_raised)
        else $error("frame end flag not raised");
    a_shared_irq_gate: assert property (
        frame_end_flag && frame_end_unmask |=> !irq_b)
        else $error("shared interrupt not driven low");
    a_frame_end_clear: assert property (
        wr_stat && !reg_wdata[`LSS_ST_FRAME_END] && !frame_end
        |=> !frame_end_flag)
        else $error("frame end flag not cleared");
    a_write_one_keeps: assert property (
        frame_end_flag && wr_stat && reg_wdata[`LSS_ST_FRAME_END]
        |=> frame_end_flag)
        else $error("write of one cleared flag");
    a_sync_read_only: assert property (
        sync_lost_flag && !off_pulse |=> sync_lost_flag)
        else $error("sync flag lost without disable");
    a_off_flushes_fifo: assert property (
        off_pulse && !underrun_ev |=> fifo_reset && !fifo_underrun_flag)
        else $error("disable did not flush fifo");
    sequence s_bias_hit;
        bias_hit;
    endsequence
    a_bias_hold: assert property (
        s_bias_hit |=> bias_count_flag && !bias_hit &&
        bias_count == $past(bias_toggles_per_irq))
        else $error("bias counter not held");
    a_line_hit_set: assert property (
        line_start && line_match |=> line_hit_flag)
        else $error("line hit flag not set");
    a_line_pin_gate: assert property (
        !line_irq_mask |=> line_irq_b)
        else $error("dedicated line output not masked");
    a_underrun_set: assert property (
        underrun_ev |=> fifo_underrun_flag [*2] or
        (fifo_underrun_flag ##1 !fifo_underrun_flag))
        else $error("underrun flag not set");
    a_palette_held: assert property (
        palette_loaded_flag && palette_load_mode == `LSS_PLM_PALETTE &&
        !off_pulse |=> palette_loaded_flag)
        else $error("palette flag cleared by write");
    a_fill_no_dma: assert property (
        !show_video |=> !dma_fetch_en &&
        pixel_out == $past(fill_pixel_value))
        else $error("fetch or wrong pixel on fill line");
    a_subpanel_off: assert property (
        !subpanel_on |=> pixel_out == $past(video_pixel))
        else $error("video replaced while subpanel off");
endmodule

/* File: lss_panel_model.sv */
/*
 * Panel-side model: line timing and frame-buffer pixels per line.
 * Assumes run_line is a one-cycle pulse made on core_clk.
 */
`timescale 1ns/1ps
module lss_panel_model import lss_pkg::*; #(
    parameter int LINE_LEN = 6
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run_line,
    input wire lss_line_t line_no,
    output logic line_start,
    output logic line_end,
    output lss_line_t current_line,
    output lss_pix_t video_pixel
);
    int cnt;
    // Pixel follows the line so the bench can predict it
    assign video_pixel = {6'h2a, current_line};
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            line_start <= 1'b0;
            line_end <= 1'b0;
            current_line <= '0;
        end else begin
            line_start <= run_line;
            line_end <= (cnt == 1);
            if (run_line) begin
                current_line <= line_no;
                cnt <= LINE_LEN;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

/* File: tb_lss_status_subpanel.sv */
/*
 * Self-checking bench of the status and subpanel block.
 * Assumes the panel model file and one 100 MHz clock.
 */
`timescale 1ns/1ps
`include "lss_defs.svh"
module tb_lss_status_subpanel import lss_pkg::*; ();
    localparam lss_addr_t CT = `LSS_CTRL_OFS;
    localparam lss_addr_t ST = `LSS_STATUS_OFS;
    localparam lss_addr_t SP = `LSS_SUBPANEL_OFS;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    lss_addr_t addr = '0;
    lss_word_t wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] evt = '0;
    logic fifo_empty = 1'b0;
    logic run_l = 1'b0;
    lss_line_t line_no = '0;
    lss_line_t lpp = 10'h00f;
    lss_word_t rdata;
    lss_line_t cur;
    lss_pix_t vpix, pix;
    logic ls, le, dma, frst, on, irq_b, lirq_b;
    int mismatches = 0;
    int checks_done = 0;

    always #5 core_clk = ~core_clk;

    lss_status_subpanel #(.BIAS_W(8)) lss_status_subpanel_i (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .frame_end(evt[0]), .sync_bad(evt[1]), .bias_toggle(evt[2]),
        .line_start(ls), .line_end(le), .current_line(cur),
        .lines_per_panel(lpp), .fifo_empty(fifo_empty),
        .pix_take(evt[3]), .palette_done(evt[4]), .video_pixel(vpix),
        .pixel_out(pix), .dma_fetch_en(dma), .fifo_reset(frst),
        .controller_on(on), .irq_b(irq_b), .line_irq_b(lirq_b));
    lss_panel_model #(.LINE_LEN(6)) lss_panel_model_i (
        .core_clk(core_clk), .rst_b(rst_b), .run_line(run_l),
        .line_no(line_no), .line_start(ls), .line_end(le),
        .current_line(cur), .video_pixel(vpix));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input lss_word_t e, lss_word_t g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr_reg(input lss_addr_t a, input lss_word_t d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input lss_addr_t a, lss_word_t e, string nm);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    // One-cycle event pulse, then time for flag and irq to settle
    task automatic ev(input int k);
        @(posedge core_clk);
        evt[k] <= 1'b1;
        @(posedge core_clk);
        evt <= '0;
        idle(3);
    endtask
    // Returns mid-line; the line ends three cycles later
    task automatic line(input int n);
        @(posedge core_clk);
        run_l <= 1'b1;
        line_no <= n[9:0];
        @(posedge core_clk);
        run_l <= 1'b0;
        idle(3);
    endtask

    task automatic t_frame();
        chk("reset lines", 32'h3, {30'h0, irq_b, lirq_b});
        rd_chk(ST, 0, "status reset");
        rd_chk(SP, 0, "subpanel reset");
        rd_chk(8'h1c, 0, "unmapped");
        ev(0);
        rd_chk(ST, 32'h3, "done while off");
        wr_reg(CT, 32'h1);
        ev(0);
        chk("controller on", 1, {31'h0, on});
        rd_chk(ST, 32'h2, "frame flag");
        chk("masked irq", 1, {31'h0, irq_b});
        wr_reg(CT, 32'h3);
        rd_chk(CT, 32'h3, "control readback");
        idle(2);
        chk("frame irq", 0, {31'h0, irq_b});
        wr_reg(ST, 32'h7f);
        rd_chk(ST, 32'h2, "write one keeps");
        wr_reg(ST, 0);
        rd_chk(ST, 0, "frame clear");
        chk("irq release", 1, {31'h0, irq_b});
    endtask
    task automatic t_err();
        logic seen;
        seen = 1'b0;
        wr_reg(CT, 32'hc1);
        @(posedge core_clk);
        fifo_empty <= 1'b1;
        ev(1);
        ev(3);
        rd_chk(ST, 32'h24, "error flags");
        chk("error irq", 0, {31'h0, irq_b});
        wr_reg(ST, 0);
        rd_chk(ST, 32'h24, "errors read only");
        wr_reg(CT, 0);
        for (int i = 0; i < 2; i++) begin
            #1;
            seen |= frst;
            @(posedge core_clk);
        end
        chk("fifo reset", 1, {31'h0, seen});
        chk("controller off", 0, {31'h0, on});
        rd_chk(ST, 0, "errors off clear");
        @(posedge core_clk);
        fifo_empty <= 1'b0;
    endtask
    task automatic t_bias();
        wr_reg(`LSS_TIMING2_OFS, 32'h3);
        rd_chk(`LSS_TIMING2_OFS, 3, "bias field");
        wr_reg(CT, 32'h21);
        ev(2);
        ev(2);
        rd_chk(ST, 0, "two toggles");
        ev(2);
        rd_chk(ST, 32'h8, "third toggle");
        chk("bias irq", 0, {31'h0, irq_b});
        ev(2);
        ev(2);
        ev(2);
        wr_reg(ST, 0);
        ev(2);
        ev(2);
        rd_chk(ST, 0, "held while set");
        ev(2);
        rd_chk(ST, 32'h8, "reloaded count");
        wr_reg(ST, 0);
    endtask
    task automatic t_line();
        wr_reg(`LSS_LINE_INT_OFS, 32'h5);
        rd_chk(`LSS_LINE_INT_OFS, 5, "line number");
        wr_reg(CT, 32'h5);
        line(4);
        chk("other line", 1, {31'h0, lirq_b});
        idle(6);
        line(5);
        chk("line pin", 0, {31'h0, lirq_b});
        chk("shared masked", 1, {31'h0, irq_b});
        rd_chk(`LSS_DISP_OFS, 5, "display line");
        wr_reg(CT, 32'hd);
        idle(2);
        chk("shared line", 0, {31'h0, irq_b});
        wr_reg(ST, 0);
        rd_chk(ST, 0, "line write clear");
        wr_reg(CT, 32'h15);
        line(5);
        chk("line hit again", 0, {31'h0, lirq_b});
        idle(6);
        chk("line auto clear", 1, {31'h0, lirq_b});
    endtask
    task automatic t_pal();
        wr_reg(CT, 32'h10_0101);
        ev(4);
        rd_chk(ST, 32'h40, "palette set");
        wr_reg(ST, 0);
        rd_chk(ST, 32'h40, "palette kept");
        wr_reg(CT, 32'h10_0100);
        rd_chk(ST, 0, "palette off clear");
        for (int m = 0; m < 4; m += 1 + (m == 0)) begin
            wr_reg(CT, (m << 20) | 32'h101);
            ev(4);
            wr_reg(ST, 0);
            rd_chk(ST, 0, "palette write clear");
        end
    endtask
    task automatic spx(input lss_word_t sp, input int n, input bit vid);
        wr_reg(SP, sp);
        line(n);
        chk("pixel", vid ? {22'h2a, n[9:0]} : 32'h1234,
            {16'h0, pix});
        chk("fetch", {31'h0, vid}, {31'h0, dma});
        idle(6);
    endtask
    task automatic t_sub();
        wr_reg(CT, 32'h1);
        wr_reg(SP, 32'hffff_ffff);
        rd_chk(SP, 32'ha3ff_ffff, "subpanel fields");
        spx(32'h8003_1234, 3, 1);
        spx(32'h8003_1234, 4, 0);
        spx(32'ha003_1234, 3, 0);
        spx(32'ha003_1234, 4, 1);
        spx(32'h2003_1234, 3, 1);
        spx(32'ha014_1234, 2, 0);
        spx(32'h8014_1234, 2, 1);
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        idle(1);
        t_frame();
        t_err();
        t_bias();
        t_line();
        t_pal();
        t_sub();
        summarize();
    end
    // Whole run takes a few hundred cycles
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
endmodule
